// ===== hdl/ctsr_regs.sv
// Charger thermistor thresholds, current limit readback and input status.
//
// Summary of operation
// [RULE_01] Thermistor control at 0x18 resets to 0x54.
// [RULE_02] Bits 7-6 pick cool comparator level.
// [RULE_03] Bits 3-2 pick output hot limit.
// [RULE_04] Bit 1 picks output cold limit.
// [RULE_05] Bit 0 overrides thermistor, temperature good.
// [RULE_06] Override forces four temperature flags to zero.
// [RULE_07] Read-only 16-bit register 0x19 resets zero.
// [RULE_08] Limit in bits 8-0, 10mA steps, clamped.
// [RULE_09] Read-only status 0x1B, reset zero, bit4 zero.
// [RULE_10] Bit 7 shows current loop regulating.
// [RULE_11] Bit 6 shows voltage loop regulating.
// [RULE_12] Bit 5 shows host timer expired.
// [RULE_13] Bit 3 shows input power good.
// [RULE_14] Bit 2 shows second adapter present.
// [RULE_15] Bit 1 shows first adapter present.
// [RULE_16] Bit 0 shows bus input present.
// [RULE_17] Bits 5-4 pick warm level, default one.
// [RULE_18] Timer expiry or soft reset restore defaults.
// [RULE_19] Writes to read-only registers are ignored.
`include "ctsr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module ctsr_regs (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        rst,

    // Register access port from the serial host engine.
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [15:0] reg_rdata,
    output var  logic        reg_rd_valid,

    // Reset requests from on-chip logic, one-cycle pulses.
    input  wire logic        host_timer_expire,
    input  wire logic        soft_reg_reset,

    // Levels from on-chip logic on this clock.
    input  wire logic        host_timer_expired,
    input  wire logic        output_mode,
    input  wire logic [8:0]  optimized_current_limit,

    // Asynchronous analog comparator levels.
    input  wire logic        input_current_regulation,
    input  wire logic        output_current_regulation,
    input  wire logic        input_voltage_regulation,
    input  wire logic        output_voltage_regulation,
    input  wire logic        input_good_raw,
    input  wire logic        second_adapter_input,
    input  wire logic        first_adapter_input,
    input  wire logic        bus_input,
    input  wire logic [3:0]  thermistor_input,

    // Thermistor settings driven to the analog front end.
    output var  logic [1:0]  cool_threshold_sel,
    output var  logic [1:0]  warm_threshold_sel,
    output var  logic [1:0]  output_mode_hot_limit,
    output var  logic        output_mode_cold_limit,
    output var  logic        temp_input_override,
    output var  logic [9:0]  cool_level_permille,
    output var  logic [7:0]  hot_limit_degc,
    output var  logic        hot_check_en,
    output var  logic [7:0]  cold_limit_degc,

    // Qualified temperature view.
    output var  logic [3:0]  temp_status,
    output var  logic        temp_good
);

    // Synchronised analog levels.
    logic [11:0]             sync_lvl;
    logic                    cur_in_s;
    logic                    cur_out_s;
    logic                    volt_in_s;
    logic                    volt_out_s;
    logic                    good_s;
    logic                    ac2_s;
    logic                    ac1_s;
    logic                    bus_s;
    logic [3:0]              therm_s;

    // Register contents.
    logic [7:0]              therm_ctrl;
    logic [15:0]             ilim_readback;
    logic [7:0]              charger_status;

    // Decoded access.
    ctsr_pkg::ctsr_sel_t     sel;
    logic [8:0]              next_ilim;
    logic [7:0]              next_status;
    logic [15:0]             next_rdata;
    logic                    defaults_req;

    // Every analog level crosses two flip-flops before logic sees it.
    ctsr_sync #(
        .WIDTH (12)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in ({input_current_regulation, output_current_regulation,
                    input_voltage_regulation, output_voltage_regulation,
                    input_good_raw, second_adapter_input,
                    first_adapter_input, bus_input, thermistor_input}),
        .sync_out (sync_lvl)
    );

    // Unpack the synchronised group by name.
    assign cur_in_s   = sync_lvl[11];
    assign cur_out_s  = sync_lvl[10];
    assign volt_in_s  = sync_lvl[9];
    assign volt_out_s = sync_lvl[8];
    assign good_s     = sync_lvl[7];
    assign ac2_s      = sync_lvl[6];
    assign ac1_s      = sync_lvl[5];
    assign bus_s      = sync_lvl[4];
    assign therm_s    = sync_lvl[3:0];

    // Address decode; anything else reads zero and ignores writes.
    always_comb begin
        case (reg_addr)
            `CTSR_OFF_THERM:  sel = ctsr_pkg::CTSR_SEL_THERM;
            `CTSR_OFF_ILIM:   sel = ctsr_pkg::CTSR_SEL_ILIM;
            `CTSR_OFF_STATUS: sel = ctsr_pkg::CTSR_SEL_STATUS;
            default:          sel = ctsr_pkg::CTSR_SEL_NONE;
        endcase
    end

    // Watchdog expiry and software reset share one restore path.
    assign defaults_req = host_timer_expire | soft_reg_reset; // [RULE_18]

    // Thermistor control; a restore in the same cycle as a write wins.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            therm_ctrl <= `CTSR_THERM_RESET; // [RULE_01] [RULE_17]
        end else if (defaults_req) begin
            therm_ctrl <= `CTSR_THERM_RESET; // [RULE_18]
        end else if (reg_wr && sel == ctsr_pkg::CTSR_SEL_THERM) begin
            therm_ctrl <= reg_wdata[7:0];
        end
    end

    // Readback value; codes under the 100 mA floor read as the floor.
    always_comb begin
        if (optimized_current_limit < `CTSR_ILIM_MIN_CODE) begin
            next_ilim = `CTSR_ILIM_MIN_CODE; // [RULE_08]
        end else begin
            next_ilim = optimized_current_limit;
        end
    end

    // The readback follows the optimizer; bus writes never reach it.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ilim_readback <= `CTSR_ILIM_RESET; // [RULE_07]
        end else begin
            ilim_readback <= {7'h00, next_ilim}; // [RULE_08] [RULE_19]
        end
    end

    // Status bits; the loop flags follow the active power direction.
    always_comb begin
        next_status                    = `CTSR_STATUS_RESET;
        next_status[`CTSR_ST_CURRENT]  = output_mode ? cur_out_s
                                                     : cur_in_s;  // [RULE_10]
        next_status[`CTSR_ST_VOLTAGE]  = output_mode ? volt_out_s
                                                     : volt_in_s; // [RULE_11]
        next_status[`CTSR_ST_TIMER]    = host_timer_expired; // [RULE_12]
        next_status[`CTSR_ST_RSVD]     = 1'b0;  // [RULE_09]
        next_status[`CTSR_ST_GOOD]     = good_s; // [RULE_13]
        next_status[`CTSR_ST_AC2]      = ac2_s;  // [RULE_14]
        next_status[`CTSR_ST_AC1]      = ac1_s;  // [RULE_15]
        next_status[`CTSR_ST_BUS]      = bus_s;  // [RULE_16]
    end

    // Status is live state only; it ignores every bus write.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            charger_status <= `CTSR_STATUS_RESET; // [RULE_09]
        end else begin
            charger_status <= next_status; // [RULE_19]
        end
    end

    // Read mux; narrow registers sit in the low bits with zeros above.
    always_comb begin
        case (sel)
            ctsr_pkg::CTSR_SEL_THERM:  next_rdata = {8'h00, therm_ctrl};
            ctsr_pkg::CTSR_SEL_ILIM:   next_rdata = ilim_readback;
            ctsr_pkg::CTSR_SEL_STATUS: next_rdata = {8'h00, charger_status};
            default:                   next_rdata = 16'h0000;
        endcase
    end

    // The valid pulse marks the one cycle after a read is taken.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd;
        end
    end

    // Read data is captured on the request edge and held until the next,
    // so a slow host may pick it up late without a second read.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // Cool select copy; it steers the rising comparator level.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cool_threshold_sel <= 2'h1;
        end else begin
            cool_threshold_sel <=
                therm_ctrl[`CTSR_COOL_MSB:`CTSR_COOL_LSB]; // [RULE_02]
        end
    end

    // Warm select copy; only stored, its levels live in the front end.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            warm_threshold_sel <= 2'h1;
        end else begin
            warm_threshold_sel <=
                therm_ctrl[`CTSR_WARM_MSB:`CTSR_WARM_LSB]; // [RULE_17]
        end
    end

    // Hot limit code copy for the output-mode temperature check.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            output_mode_hot_limit <= 2'h1;
        end else begin
            output_mode_hot_limit <=
                therm_ctrl[`CTSR_HOT_MSB:`CTSR_HOT_LSB]; // [RULE_03]
        end
    end

    // Cold limit bit copy for the output-mode temperature check.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            output_mode_cold_limit <= 1'b0;
        end else begin
            output_mode_cold_limit <= therm_ctrl[`CTSR_COLD_BIT]; // [RULE_04]
        end
    end

    // Override copy; the front end uses it to skip its own sensor checks.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            temp_input_override <= 1'b0;
        end else begin
            temp_input_override <=
                therm_ctrl[`CTSR_OVERRIDE_BIT]; // [RULE_05]
        end
    end

    // Cool rising level, in tenths of a percent of the regulator rail.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cool_level_permille <= `CTSR_COOL_LVL1;
        end else begin
            case (therm_ctrl[`CTSR_COOL_MSB:`CTSR_COOL_LSB])
                2'h0:    cool_level_permille <= `CTSR_COOL_LVL0; // [RULE_02]
                2'h1:    cool_level_permille <= `CTSR_COOL_LVL1; // [RULE_02]
                2'h2:    cool_level_permille <= `CTSR_COOL_LVL2; // [RULE_02]
                default: cool_level_permille <= `CTSR_COOL_LVL3; // [RULE_02]
            endcase
        end
    end

    // Output-mode hot limit; code three keeps the last step, since the
    // check itself is switched off by its own enable below.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hot_limit_degc <= `CTSR_HOT_LIM1;
        end else begin
            case (therm_ctrl[`CTSR_HOT_MSB:`CTSR_HOT_LSB])
                2'h0:    hot_limit_degc <= `CTSR_HOT_LIM0; // [RULE_03]
                2'h1:    hot_limit_degc <= `CTSR_HOT_LIM1; // [RULE_03]
                default: hot_limit_degc <= `CTSR_HOT_LIM2; // [RULE_03]
            endcase
        end
    end

    // Hot check enable; hot code three switches the hot check off.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hot_check_en <= 1'b1;
        end else begin
            hot_check_en <= therm_ctrl[`CTSR_HOT_MSB:`CTSR_HOT_LSB]
                            != `CTSR_HOT_OFF_CODE; // [RULE_03]
        end
    end

    // Output-mode cold limit, kept as a signed byte in degrees.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cold_limit_degc <= `CTSR_COLD_LIM0;
        end else if (therm_ctrl[`CTSR_COLD_BIT]) begin
            cold_limit_degc <= `CTSR_COLD_LIM1; // [RULE_04]
        end else begin
            cold_limit_degc <= `CTSR_COLD_LIM0; // [RULE_04]
        end
    end

    // Temperature flags, bit 3 hot down to bit 0 cold; they show a normal
    // reading while the override is set.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            temp_status <= 4'h0;
        end else if (therm_ctrl[`CTSR_OVERRIDE_BIT]) begin
            temp_status <= 4'h0; // [RULE_06]
        end else begin
            temp_status <= therm_s;
        end
    end

    // Temperature verdict. With the override set the thermistor is not
    // trusted, so charging may proceed even with a broken sensor, which is
    // the user's stated trade.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            temp_good <= 1'b0;
        end else if (therm_ctrl[`CTSR_OVERRIDE_BIT]) begin
            temp_good <= 1'b1; // [RULE_05]
        end else begin
            temp_good <= ~((therm_s[3] & hot_check_en) | therm_s[0]);
        end
    end

endmodule : ctsr_regs

`default_nettype wire

// ===== hdl/ctsr_defs.svh
// Offsets, field positions, reset values and scale constants of the bank.
`ifndef CTSR_DEFS_SVH
`define CTSR_DEFS_SVH

// Register offsets.
`define CTSR_OFF_THERM          8'h18
`define CTSR_OFF_ILIM           8'h19
`define CTSR_OFF_STATUS         8'h1B

// Reset values.
`define CTSR_THERM_RESET        8'h54
`define CTSR_ILIM_RESET         16'h0000
`define CTSR_STATUS_RESET       8'h00

// Thermistor control field positions.
`define CTSR_COOL_MSB           7
`define CTSR_COOL_LSB           6
`define CTSR_WARM_MSB           5
`define CTSR_WARM_LSB           4
`define CTSR_HOT_MSB            3
`define CTSR_HOT_LSB            2
`define CTSR_COLD_BIT           1
`define CTSR_OVERRIDE_BIT       0

// Status register bit positions.
`define CTSR_ST_CURRENT         7
`define CTSR_ST_VOLTAGE         6
`define CTSR_ST_TIMER           5
`define CTSR_ST_RSVD            4
`define CTSR_ST_GOOD            3
`define CTSR_ST_AC2             2
`define CTSR_ST_AC1             1
`define CTSR_ST_BUS             0

// Current limit scale: 10 mA per code, 100 mA floor.
`define CTSR_ILIM_STEP_MA       10
`define CTSR_ILIM_MIN_MA        100
`define CTSR_ILIM_MIN_CODE      9'h00A

// Cool comparator levels in tenths of a percent of the regulator rail.
`define CTSR_COOL_LVL0          10'h2C7
`define CTSR_COOL_LVL1          10'h2AC
`define CTSR_COOL_LVL2          10'h28F
`define CTSR_COOL_LVL3          10'h270

// Output-mode temperature limits in degrees Celsius.
`define CTSR_HOT_LIM0           8'h37
`define CTSR_HOT_LIM1           8'h3C
`define CTSR_HOT_LIM2           8'h41
`define CTSR_HOT_OFF_CODE       2'h3
`define CTSR_COLD_LIM0          8'hF6
`define CTSR_COLD_LIM1          8'hEC

`endif

// ===== hdl/ctsr_pkg.sv
// Types shared by the charger thermal and status register bank.
package ctsr_pkg;

    // Which register a bus address selects.
    typedef enum logic [1:0] {
        CTSR_SEL_NONE,
        CTSR_SEL_THERM,
        CTSR_SEL_ILIM,
        CTSR_SEL_STATUS
    } ctsr_sel_t;

endpackage : ctsr_pkg

// ===== hdl/ctsr_sync.sv
// Two-stage synchroniser for a group of independent level signals.
`timescale 1ns/1ps
`default_nettype none

module ctsr_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // Asynchronous levels in, synchronised levels out.
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // The first stage feeds only the second; bits are not coherent as a word.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : ctsr_sync

`default_nettype wire

// ===== sim/ctsr_regs_chk.sv
// Port assertions for the charger thermal and status register bank.
`timescale 1ns/1ps
`default_nettype none

module ctsr_regs_chk (
    // Clock, reset and access port.
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_rd_valid,
    input wire logic        host_timer_expire,
    input wire logic        soft_reg_reset,
    // Field and threshold outputs.
    input wire logic [1:0]  cool_threshold_sel,
    input wire logic [1:0]  warm_threshold_sel,
    input wire logic [1:0]  output_mode_hot_limit,
    input wire logic        output_mode_cold_limit,
    input wire logic        temp_input_override,
    input wire logic [9:0]  cool_level_permille,
    input wire logic [7:0]  hot_limit_degc,
    input wire logic        hot_check_en,
    input wire logic [7:0]  cold_limit_degc,
    input wire logic [3:0]  temp_status,
    input wire logic        temp_good
);
    default clocking dcb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // The five fields packed back in register order.
    wire logic [7:0] fld = {cool_threshold_sel, warm_threshold_sel,
        output_mode_hot_limit, output_mode_cold_limit, temp_input_override};

    // Override is given three cycles to reach the registered flags.
    property p_ovr_status;
        temp_input_override [*3] |-> temp_status == 4'h0;
    endproperty
    a_ovr_status: assert property (p_ovr_status)
        else $error("flags not cleared under override");
    property p_ovr_good;
        temp_input_override [*3] |-> temp_good;
    endproperty
    a_ovr_good: assert property (p_ovr_good)
        else $error("temperature not good under override");
    property p_cool_lvl;
        cool_level_permille == (cool_threshold_sel == 2'h0 ? 10'h2C7 :
            cool_threshold_sel == 2'h1 ? 10'h2AC :
            cool_threshold_sel == 2'h2 ? 10'h28F : 10'h270);
    endproperty
    a_cool_lvl: assert property (p_cool_lvl)
        else $error("cool level does not match its code");
    property p_hot_lim;
        hot_check_en == (output_mode_hot_limit != 2'h3) &&
        hot_limit_degc == (output_mode_hot_limit == 2'h0 ? 8'h37 :
            output_mode_hot_limit == 2'h1 ? 8'h3C : 8'h41);
    endproperty
    a_hot_lim: assert property (p_hot_lim)
        else $error("hot limit does not match its code");
    property p_cold_lim;
        cold_limit_degc == (output_mode_cold_limit ? 8'hEC : 8'hF6);
    endproperty
    a_cold_lim: assert property (p_cold_lim)
        else $error("cold limit does not match its code");
    property p_defaults;
        host_timer_expire || soft_reg_reset |-> ##2 fld == 8'h54;
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("fields not restored after reset request");
    property p_write;
        reg_wr && reg_addr == 8'h18 && !host_timer_expire && !soft_reg_reset
            |-> ##2 fld == ($past(reg_wdata, 2) & 16'h00FF);
    endproperty
    a_write: assert property (p_write)
        else $error("written fields not shown two cycles on");
    property p_ilim;
        reg_rd && reg_addr == 8'h19 |=> reg_rd_valid &&
            reg_rdata[15:9] == 7'h00 && reg_rdata[8:0] >= 9'h00A;
    endproperty
    a_ilim: assert property (p_ilim)
        else $error("limit readback out of range");

    // Main scenarios that should be seen.
    c_override: cover property (temp_input_override [*3]);
    c_expire: cover property (host_timer_expire);
    c_soft_write: cover property (soft_reg_reset && reg_wr);
endmodule : ctsr_regs_chk

bind ctsr_regs ctsr_regs_chk chk (.sys_clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .reg_rd_valid, .host_timer_expire,
    .soft_reg_reset, .cool_threshold_sel, .warm_threshold_sel,
    .output_mode_hot_limit, .output_mode_cold_limit, .temp_input_override,
    .cool_level_permille, .hot_limit_degc, .hot_check_en, .cold_limit_degc,
    .temp_status, .temp_good);

`default_nettype wire

// ===== sim/ctsr_host.sv
// Host model that reads and writes the bank through its access port.
`timescale 1ns/1ps
`default_nettype none

module ctsr_host (
    // Clock.
    input  wire logic        sys_clk,
    // Access port towards the bank.
    output var  logic [7:0]  reg_addr,
    output var  logic [15:0] reg_wdata,
    output var  logic        reg_wr,
    output var  logic        reg_rd,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_rd_valid
);
    // Idle port at time zero.
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Released lines show the inverse so a stale value is never trusted.
    task automatic write(input logic [7:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : write

    // A missing valid pulse turns the returned word unknown.
    task automatic read(input logic [7:0] a, output logic [15:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = (reg_rd_valid === 1'b1) ? reg_rdata : 16'hXXXX;
    endtask : read
endmodule : ctsr_host

`default_nettype wire

// ===== sim/ctsr_regs_tb.sv
// Self-checking bench for the charger thermal and status register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
    $display("Error at %0t ns: got %h expected %h", $time, (a), (e)); end end

module ctsr_regs_tb;
    // Bench-driven inputs, all defined at time zero.
    logic sys_clk = 1'b0, rst = 1'b1, host_timer_expire = 1'b0;
    logic soft_reg_reset = 1'b0, host_timer_expired = 1'b0;
    logic output_mode = 1'b0, input_current_regulation = 1'b0;
    logic output_current_regulation = 1'b0, input_voltage_regulation = 1'b0;
    logic output_voltage_regulation = 1'b0, input_good_raw = 1'b0;
    logic second_adapter_input = 1'b0, first_adapter_input = 1'b0;
    logic bus_input = 1'b0;
    logic [8:0]  optimized_current_limit = 9'h000;
    logic [3:0]  thermistor_input = 4'h0;
    // Access port and bank outputs.
    logic [7:0]  reg_addr, hot_limit_degc, cold_limit_degc;
    logic [15:0] reg_wdata, reg_rdata, rd;
    logic [1:0]  cool_threshold_sel, warm_threshold_sel, output_mode_hot_limit;
    logic [9:0]  cool_level_permille;
    logic [3:0]  temp_status;
    logic reg_wr, reg_rd, reg_rd_valid, output_mode_cold_limit;
    logic temp_input_override, hot_check_en, temp_good;
    logic [9:0]  cool_ref [4] = '{10'h2C7, 10'h2AC, 10'h28F, 10'h270};
    logic [7:0]  hot_ref [3] = '{8'h37, 8'h3C, 8'h41};
    int errors = 0, checks = 0, cycles = 0;

    ctsr_regs dut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .reg_rd_valid, .host_timer_expire, .soft_reg_reset,
        .host_timer_expired, .output_mode, .optimized_current_limit,
        .input_current_regulation, .output_current_regulation,
        .input_voltage_regulation, .output_voltage_regulation,
        .input_good_raw, .second_adapter_input, .first_adapter_input,
        .bus_input, .thermistor_input, .cool_threshold_sel,
        .warm_threshold_sel, .output_mode_hot_limit, .output_mode_cold_limit,
        .temp_input_override, .cool_level_permille, .hot_limit_degc,
        .hot_check_en, .cold_limit_degc, .temp_status, .temp_good);
    ctsr_host host (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .reg_rd_valid);

    // Clock at 8 ns.
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    // Cuts a hang short; the whole run needs well under a thousand cycles.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            results();
        end
    end

    task automatic results();
        $display("Checks %0d, errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wait_cyc

    task automatic t_reset();
        host.write(8'h1A, 16'h00FF);
        host.read(8'h18, rd);
        `CHK(rd, 16'h0054)
        host.read(8'h1B, rd);
        `CHK(rd, 16'h0000)
        host.read(8'h1A, rd);
        `CHK(rd, 16'h0000)
        `CHK(warm_threshold_sel, 2'h1)
        $display("Test reset values done");
    endtask : t_reset

    // Every code of every field except the override, which stays 0, read back and decoded.
    task automatic t_fields();
        logic [7:0] v;
        for (int c = 0; c < 4; c++) begin
            v = {c[1:0], c[1:0], c[1:0], c[0], 1'b0};
            host.write(8'h18, {8'h00, v});
            wait_cyc(2);
            host.read(8'h18, rd);
            `CHK(rd, {8'h00, v})
            `CHK(cool_level_permille, cool_ref[c])
            `CHK(hot_check_en, c != 3)
            if (c < 3) `CHK(hot_limit_degc, hot_ref[c])
            `CHK(cold_limit_degc, c[0] ? 8'hEC : 8'hF6)
        end
        $display("Test field codes done");
    endtask : t_fields

    task automatic t_override();
        thermistor_input = 4'hF;
        host.write(8'h18, 16'h0054);
        wait_cyc(4);
        `CHK(temp_status, 4'hF)
        `CHK(temp_good, 1'b0)
        host.write(8'h18, 16'h0055);
        wait_cyc(4);
        `CHK(temp_status, 4'h0)
        `CHK(temp_good, 1'b1)
        thermistor_input = 4'h0;
        $display("Test override done");
    endtask : t_override

    task automatic t_limit();
        optimized_current_limit = 9'h14A;
        host.write(8'h19, 16'hFFFF);
        wait_cyc(2);
        host.read(8'h19, rd);
        `CHK(rd, 16'h014A)
        optimized_current_limit = 9'h005;
        wait_cyc(2);
        host.read(8'h19, rd);
        `CHK(rd, 16'h000A)
        $display("Test current limit done");
    endtask : t_limit

    // One flag at a time in both modes, then all of them with the timer.
    task automatic t_status();
        logic [7:0] v, e;
        host.write(8'h1B, 16'hFFFF);
        for (int i = 0; i < 18; i++) begin
            v = (i < 16) ? 8'h01 << (i / 2) : 8'hFF;
            output_mode = i[0];
            host_timer_expired = (i >= 16);
            {input_current_regulation, output_current_regulation,
             input_voltage_regulation, output_voltage_regulation,
             input_good_raw, second_adapter_input, first_adapter_input,
             bus_input} = v;
            e = {i[0] ? v[6] : v[7], i[0] ? v[4] : v[5], i >= 16, 1'b0,
                 v[3:0]};
            wait_cyc(4);
            host.read(8'h1B, rd);
            `CHK(rd, {8'h00, e})
            `CHK(rd[3:0], e[3:0])
        end
        $display("Test status flags done");
    endtask : t_status

    // A write that meets a soft reset is lost.
    task automatic t_resets();
        host.write(8'h18, 16'h00AB);
        host_timer_expire = 1'b1;
        @(negedge sys_clk);
        host_timer_expire = 1'b0;
        host.read(8'h18, rd);
        `CHK(rd, 16'h0054)
        host.write(8'h18, 16'h00AB);
        fork
            host.write(8'h18, 16'h00FF);
            begin
                @(negedge sys_clk);
                soft_reg_reset = 1'b1;
                @(negedge sys_clk);
                soft_reg_reset = 1'b0;
            end
        join
        host.read(8'h18, rd);
        `CHK(rd, 16'h0054)
        $display("Test reset requests done");
    endtask : t_resets

    // Reset for 12 cycles, then the scenarios in turn.
    initial begin
        repeat (12) @(negedge sys_clk);
        `CHK(dut.ilim_readback, 16'h0000)
        rst = 1'b0;
        t_reset();
        t_fields();
        t_override();
        t_limit();
        t_status();
        t_resets();
        results();
    end
endmodule : ctsr_regs_tb

`default_nettype wire
